// ### include/ccr_regs.vh
`ifndef CCR_REGS_VH
`define CCR_REGS_VH

// Register addresses.
`define CCR_ADDR_CHG_BOOST     8'h01
`define CCR_ADDR_BLIM_FAST     8'h02
`define CCR_ADDR_PRE_TERM      8'h03
`define CCR_ADDR_FIRST         8'h01
`define CCR_ADDR_LAST          8'h03

// Field positions in charge_and_boost_control.
`define CCR_PULSE_DIS_BIT      7
`define CCR_WD_RESTART_BIT     6
`define CCR_BOOST_EN_BIT       5
`define CCR_CHG_EN_BIT         4
`define CCR_SYSMIN_HI          3
`define CCR_SYSMIN_LO          1
`define CCR_MINBAT_BIT         0

// Field positions in boost_limit_and_fast_charge_current.
`define CCR_BOOST_CURRENT_LIMIT_BIT      7
`define CCR_FULL_ON_BIT        6
`define CCR_FAST_HI            5
`define CCR_FAST_LO            0

// Field positions in precharge_and_termination_current.
`define CCR_PRE_HI             7
`define CCR_PRE_LO             4
`define CCR_TERM_HI            3
`define CCR_TERM_LO            0

// Power-on values.
`define CCR_RST_CHG_BOOST      8'h1A
`define CCR_RST_BLIM_FAST      8'hA2
`define CCR_RST_PRE_TERM       8'h22

// Bits that fall back to power-on value on watchdog expiry.
`define CCR_WDMASK_CHG_BOOST   8'h50
`define CCR_WDMASK_BLIM_FAST   8'hBF
`define CCR_WDMASK_PRE_TERM    8'hFF

// Clamp limits, and the fast charge code that disables charging.
`define CCR_FAST_MAX           6'h32
`define CCR_PRE_MAX            4'hC
`define CCR_FAST_ZERO          6'h00

// Input current limit code below which the high-resistance switch is used.
`define CCR_ILIM_700MA         5'h06

`endif

// ### core/ccr_clamp.v
`timescale 1ns/1ps
// Clamps written field values before they land in the registers.
module ccr_clamp (
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   output reg  [7:0] cdata
);
`include "ccr_regs.vh"
   always @* begin
      cdata = wdata;
      if (addr == `CCR_ADDR_BLIM_FAST &&
          wdata[`CCR_FAST_HI:`CCR_FAST_LO] > `CCR_FAST_MAX) begin
         cdata[`CCR_FAST_HI:`CCR_FAST_LO] = `CCR_FAST_MAX;
      end
      if (addr == `CCR_ADDR_PRE_TERM &&
          wdata[`CCR_PRE_HI:`CCR_PRE_LO] > `CCR_PRE_MAX) begin
         cdata[`CCR_PRE_HI:`CCR_PRE_LO] = `CCR_PRE_MAX;
      end
   end
endmodule // ccr_clamp

// ### core/ccr_bank.v
`timescale 1ns/1ps
// Notes on behaviour
// - watchdog restart bit pulses, then self-clears
// - boost enable overrides charge enable
// - charge needs pin low and bit set
// - system minimum code decodes 2.6 to 3.7 V
// - boost battery threshold 2.8 V or 2.5 V
// - boost current limit 0.5 A or 1.2 A
// - full-on bit forces low-resistance switch
// - boost always uses full switch
// - fast charge 60 mA per step
// - zero fast charge disables charging
// - fast charge code clamped at 110010
// - precharge is 60 mA offset plus steps
// - precharge code clamped at 1100
// - termination is 60 mA offset plus steps
// - undefined register address is refused with NACK
// - sequential access auto-increments the address
module ccr_bank (
   input  wire       clk_sys,
   input  wire       resetn,
   input  wire       acc_start,
   input  wire [7:0] acc_addr,
   input  wire       wr_stb,
   input  wire [7:0] wr_data,
   input  wire       rd_stb,
   output reg  [7:0] rd_data,
   output wire       acc_nack,
   input  wire       reg_reset,
   input  wire       wd_expired,
   input  wire       charge_en_pin_n,
   input  wire [4:0] input_current_limit,
   output reg        watchdog_restart,
   output wire       pulse_mode_disable,
   output wire       boost_mode,
   output wire       charge_active,
   output wire [2:0] min_system_voltage,
   output wire       boost_min_bat_low,
   output wire       boost_current_limit,
   output wire       pass_device_low_res,
   output wire [5:0] fast_charge_current,
   output wire [3:0] precharge_current,
   output wire [3:0] termination_current
);
`include "ccr_regs.vh"

   reg  [7:0] chg_boost_reg;
   reg  [7:0] blim_fast_reg;
   reg  [7:0] pre_term_reg;
   reg  [7:0] ptr_reg;
   reg        pin_meta_reg;
   reg        pin_sync_reg;
   wire [7:0] wdata_clamped;

   function addr_valid;
      input [7:0] a;
      begin
         addr_valid = (a >= `CCR_ADDR_FIRST) && (a <= `CCR_ADDR_LAST);
      end
   endfunction

   ccr_clamp u_clamp (
      .addr  (ptr_reg),
      .wdata (wr_data),
      .cdata (wdata_clamped)
   );

   // The charge enable pin is asynchronous to clk_sys.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
      end else begin
         pin_meta_reg <= charge_en_pin_n;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Address pointer: loaded at start of access, bumped after each byte while it points inside the bank.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ptr_reg <= 8'h00;
      end else if (acc_start) begin
         ptr_reg <= acc_addr;
      end else if ((wr_stb || rd_stb) && addr_valid(ptr_reg)) begin
         ptr_reg <= ptr_reg + 8'h01;
      end
   end

   // A byte aimed outside the bank is refused; the protocol engine idles.
   assign acc_nack = !addr_valid(ptr_reg);

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         chg_boost_reg    <= `CCR_RST_CHG_BOOST;
         blim_fast_reg    <= `CCR_RST_BLIM_FAST;
         pre_term_reg     <= `CCR_RST_PRE_TERM;
         watchdog_restart <= 1'b0;
      end else if (reg_reset) begin
         chg_boost_reg    <= `CCR_RST_CHG_BOOST;
         blim_fast_reg    <= `CCR_RST_BLIM_FAST;
         pre_term_reg     <= `CCR_RST_PRE_TERM;
         watchdog_restart <= 1'b0;
      end else begin
         // The restart bit never holds: it fires once and reads back 0.
         watchdog_restart <= 1'b0;
         chg_boost_reg[`CCR_WD_RESTART_BIT] <= 1'b0;
         if (wd_expired) begin
            chg_boost_reg <= (chg_boost_reg & ~`CCR_WDMASK_CHG_BOOST) |
               (`CCR_RST_CHG_BOOST & `CCR_WDMASK_CHG_BOOST);
            blim_fast_reg <= (blim_fast_reg & ~`CCR_WDMASK_BLIM_FAST) |
               (`CCR_RST_BLIM_FAST & `CCR_WDMASK_BLIM_FAST);
            pre_term_reg  <= `CCR_RST_PRE_TERM;
         end else if (wr_stb) begin
            case (ptr_reg)
               `CCR_ADDR_CHG_BOOST: begin
                  chg_boost_reg <= wr_data &
                     ~(8'h01 << `CCR_WD_RESTART_BIT);
                  watchdog_restart <= wr_data[`CCR_WD_RESTART_BIT];
               end
               `CCR_ADDR_BLIM_FAST: blim_fast_reg <= wdata_clamped;
               `CCR_ADDR_PRE_TERM:  pre_term_reg  <= wdata_clamped;
               default: ;
            endcase
         end
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 8'h00;
      end else if (rd_stb || acc_start) begin
         case (acc_start ? acc_addr : ptr_reg + 8'h01)
            `CCR_ADDR_CHG_BOOST: rd_data <= chg_boost_reg;
            `CCR_ADDR_BLIM_FAST: rd_data <= blim_fast_reg;
            `CCR_ADDR_PRE_TERM:  rd_data <= pre_term_reg;
            default:             rd_data <= 8'h00;
         endcase
      end
   end

   assign pulse_mode_disable  = chg_boost_reg[`CCR_PULSE_DIS_BIT];
   assign boost_mode          = chg_boost_reg[`CCR_BOOST_EN_BIT];
   assign charge_active       = !boost_mode && !pin_sync_reg &&
      chg_boost_reg[`CCR_CHG_EN_BIT] &&
      (fast_charge_current != `CCR_FAST_ZERO);
   // Codes go straight to the analog trim; decoding to volts is there.
   assign min_system_voltage  =
      chg_boost_reg[`CCR_SYSMIN_HI:`CCR_SYSMIN_LO];
   assign boost_min_bat_low   = chg_boost_reg[`CCR_MINBAT_BIT];
   assign boost_current_limit = blim_fast_reg[`CCR_BOOST_CURRENT_LIMIT_BIT];
   assign pass_device_low_res = boost_mode ||
      blim_fast_reg[`CCR_FULL_ON_BIT] ||
      (input_current_limit >= `CCR_ILIM_700MA);
   assign fast_charge_current =
      blim_fast_reg[`CCR_FAST_HI:`CCR_FAST_LO];
   assign precharge_current   = pre_term_reg[`CCR_PRE_HI:`CCR_PRE_LO];
   assign termination_current =
      pre_term_reg[`CCR_TERM_HI:`CCR_TERM_LO];
endmodule // ccr_bank

// ### bench/ccr_bank_chk.sv
`timescale 1ns/1ps
module ccr_bank_chk (
   input wire       clk_sys, resetn, acc_start, wr_stb, reg_reset,
   input wire       wd_expired, charge_en_pin_n, watchdog_restart,
   input wire       boost_mode, acc_nack, charge_active,
   input wire       pass_device_low_res, boost_current_limit,
   input wire [7:0] acc_addr, wr_data, rd_data,
   input wire [4:0] input_current_limit,
   input wire [5:0] fast_charge_current,
   input wire [3:0] precharge_current, termination_current,
   input wire [2:0] min_system_voltage
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_WD_PULSE: assert property (
      acc_start && acc_addr == 8'h01 ##1 wr_stb && !acc_start && wr_data[6]
      && !wd_expired && !reg_reset |=> watchdog_restart ##1 !watchdog_restart)
      else $error("restart pulse wrong");
   AST_BOOST: assert property (boost_mode |-> !charge_active)
      else $error("charge during boost");
   AST_PIN: assert property (charge_active |-> !$past(charge_en_pin_n, 2))
      else $error("charge with pin high");
   AST_ZERO: assert property (charge_active |-> fast_charge_current != 6'h00)
      else $error("charge at zero current");
   AST_LOWRES: assert property (
      boost_mode || input_current_limit >= 5'h06 |-> pass_device_low_res)
      else $error("switch mode wrong");
   AST_FAST_MAX: assert property (fast_charge_current <= 6'h32)
      else $error("fast code above clamp");
   AST_PRE_MAX: assert property (precharge_current <= 4'hC)
      else $error("precharge code above clamp");
   AST_REGRST: assert property (reg_reset |=> min_system_voltage == 3'h5
      && boost_current_limit && fast_charge_current == 6'h22 && !boost_mode)
      else $error("register reset incomplete");
   AST_NACK: assert property (acc_start &&
      (acc_addr == 8'h00 || acc_addr > 8'h03) |=> acc_nack)
      else $error("bad address accepted");
   AST_RD3: assert property (acc_start && acc_addr == 8'h03 |=>
      rd_data == {precharge_current, termination_current})
      else $error("read data mismatch");
   cover property (boost_mode && pass_device_low_res);
   cover property (watchdog_restart);
   cover property (acc_nack && wr_stb);
endmodule // ccr_bank_chk
bind ccr_bank ccr_bank_chk chk_u (.*);

// ### bench/ccr_bank_tb_top.sv
`timescale 1ns/1ps
module ccr_bank_tb_top;
   reg clk_sys = 0, resetn = 0, acc_start = 0, wr_stb = 0, rd_stb = 0;
   reg reg_reset = 0, wd_expired = 0, charge_en_pin_n = 0;
   reg [7:0] acc_addr = 8'h00, wr_data = 8'h00;
   reg [4:0] input_current_limit = 5'h00;
   wire [7:0] rd_data;
   wire [5:0] fast_charge_current;
   wire [3:0] precharge_current, termination_current;
   wire [2:0] min_system_voltage;
   wire acc_nack, watchdog_restart, pulse_mode_disable, boost_mode;
   wire charge_active, boost_min_bat_low, boost_current_limit;
   wire pass_device_low_res;
   integer n_errors = 0, cmp_count = 0, cyc = 0;
   ccr_bank dut_u (.*);
   initial forever #2 clk_sys = ~clk_sys;
   // One call per falling edge, so strobes may follow back to back.
   task s(input [2:0] k, input [7:0] v); begin
      @(negedge clk_sys);
      {acc_start, wr_stb, rd_stb} = k;
      acc_addr = v;
      wr_data = v;
   end endtask
   task chk(input [7:0] v, input [7:0] e); begin
      cmp_count = cmp_count + 1;
      if (v !== e) begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
      end
   end endtask
   task rdx(input [23:0] e); integer i; begin
      s(3'h4, 8'h01);
      for (i = 2; i >= 0; i = i - 1) begin
         s({2'b00, i > 0}, 8'h00);
         chk(rd_data, e[i*8+:8]);
      end
   end endtask
   task complete_run; begin
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end endtask
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 1000) begin
         n_errors = n_errors + 1;
         complete_run;
      end
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys) resetn = 1;
      rdx(24'h1AA222);
      chk(min_system_voltage, 3'h5);
      chk(charge_active, 1'b1);
      s(3'h4, 8'h02); s(3'h2, 8'hFF); s(3'h2, 8'hF0); s(3'h2, 8'h55);
      s(3'h0, 8'h00);
      chk(acc_nack, 1'b1);
      rdx(24'h1AF2C0);
      s(3'h4, 8'h01); s(3'h2, 8'h50); s(3'h0, 8'h00);
      chk(watchdog_restart, 1'b1);
      s(3'h0, 8'h00);
      chk(watchdog_restart, 1'b0);
      charge_en_pin_n = 1;
      s(3'h0, 8'h00); s(3'h0, 8'h00); s(3'h0, 8'h00);
      chk(charge_active, 1'b0);
      charge_en_pin_n = 0;
      s(3'h4, 8'h02); s(3'h2, 8'h80); s(3'h0, 8'h00); s(3'h0, 8'h00);
      s(3'h0, 8'h00);
      chk(charge_active, 1'b0);
      s(3'h4, 8'h01); s(3'h2, 8'h30); s(3'h0, 8'h00);
      chk(boost_mode, 1'b1);
      chk(charge_active, 1'b0);
      chk(pass_device_low_res, 1'b1);
      wd_expired = 1;
      s(3'h0, 8'h00);
      wd_expired = 0;
      rdx(24'h30A222);
      reg_reset = 1;
      s(3'h0, 8'h00);
      reg_reset = 0;
      rdx(24'h1AA222);
      chk(boost_mode, 1'b0);
      input_current_limit = 5'h05;
      s(3'h0, 8'h00);
      chk(pass_device_low_res, 1'b0);
      input_current_limit = 5'h06;
      s(3'h0, 8'h00);
      chk(pass_device_low_res, 1'b1);
      input_current_limit = 5'h00;
      s(3'h4, 8'h01); s(3'h2, 8'h81); s(3'h2, 8'h42); s(3'h2, 8'h35);
      s(3'h0, 8'h00);
      chk(pass_device_low_res, 1'b1);
      chk(boost_current_limit, 1'b0);
      chk(pulse_mode_disable, 1'b1);
      chk(boost_min_bat_low, 1'b1);
      chk(min_system_voltage, 3'h0);
      chk(fast_charge_current, 6'h02);
      chk({precharge_current, termination_current}, 8'h35);
      s(3'h4, 8'h05); s(3'h0, 8'h00);
      chk(acc_nack, 1'b1);
      s(3'h4, 8'h03); s(3'h0, 8'h00);
      chk(acc_nack, 1'b0);
      chk(rd_data, 8'h35);
      complete_run;
   end
endmodule // ccr_bank_tb_top
